/* bench/rsco_board_model.sv */
module rsco_board_model (
  input  wire logic       ref_clk_i,
  input  wire logic [1:0] mode_i,
  output logic      [1:0] clock_mode_select_o
);
  timeunit 1ns; timeprecision 1ps;
  always_ff @(posedge ref_clk_i) clock_mode_select_o <= mode_i;
endmodule : rsco_board_model

/* bench/rsco_monitor.sv */
module rsco_monitor (
  input wire logic ref_clk_i, arst_n_i, soft_reset_request_bit_i, watchdog_timeout_i, test_port_enable_i,
  input wire logic reset_out_n_o, core_reset_n_o, use_crystal_osc_o, half_rate_clock_output_o,
  input wire logic debug_pin_function_o, gpio_debug_ctrl_en_o, crystal_drive_enable_o,
  input wire logic [1:0] clock_mode_select_i, clock_mode_o
);
  timeunit 1ns; timeprecision 1ps;
  // low cycles still owed on reset out
  logic [15:0] r_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i) r_q <= 16'h8000;
    else if (watchdog_timeout_i) r_q <= 16'h8000;
    else if ($rose(soft_reset_request_bit_i)) r_q <= 16'h0080;
    else if (|r_q) r_q <= r_q - 16'h0001;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_pulse_len: assert property (reset_out_n_o == !r_q) else $error("pulse");
  a_reset_now: assert property (disable iff (1'b0) !arst_n_i |-> !core_reset_n_o && !reset_out_n_o)
    else $error("reset");
  a_half_rate: assert property (1'b1 |=> $changed(half_rate_clock_output_o)) else $error("clk");
  a_mode_take: assert property (!reset_out_n_o |=> clock_mode_o == $past(clock_mode_select_i)) else $error("mode");
  a_mode_hold: assert property (reset_out_n_o && core_reset_n_o |=> $stable(clock_mode_o)) else $error("hold");
  a_osc_pick: assert property (use_crystal_osc_o == (clock_mode_o == 2'h1)) else $error("osc");
  a_test_port: assert property ($rose(test_port_enable_i) |-> ##[1:6] debug_pin_function_o) else $error("test");
  a_gpio_off: assert property (gpio_debug_ctrl_en_o == !debug_pin_function_o) else $error("gpio");
  a_crystal_drive_output_drive: assert property (crystal_drive_enable_o == (clock_mode_o == 2'h1)) else $error("crystal_drive_output");
  cover property ($rose(soft_reset_request_bit_i));
  cover property ($rose(watchdog_timeout_i));
  cover property ($rose(debug_pin_function_o));
endmodule : rsco_monitor
bind rsco_reset_clock_out rsco_monitor u_mon (.*);

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns; timeprecision 1ps;
  logic ref_clk_i = 0, arst_n_i = 1, soft_reset_request_bit_i = 0, watchdog_timeout_i = 0, test_port_enable_i = 0;
  logic reset_out_n_o, core_reset_n_o, use_crystal_osc_o, crystal_drive_enable_o, half_rate_clock_output_o;
  logic debug_pin_function_o, gpio_debug_ctrl_en_o;
  logic [1:0] clock_mode_select_i, clock_mode_o, m_q;
  int num_errors = 0, n_checks = 0, n;
  rsco_reset_clock_out DUT (.*);
  rsco_board_model u_brd (.ref_clk_i, .mode_i(m_q), .clock_mode_select_o(clock_mode_select_i));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [15:0] exp_len(logic w, logic s);
    exp_len = (w | !s) ? 16'h8000 : 16'h0080;
  endfunction : exp_len
  // one-cycle cause, then count low cycles; a soft cause shortens a long pulse
  task automatic hit(logic w, logic s, logic meas);
    if (w | s) begin
      @(posedge ref_clk_i);
      {watchdog_timeout_i, soft_reset_request_bit_i} <= {w, s};
      @(posedge ref_clk_i);
      {watchdog_timeout_i, soft_reset_request_bit_i} <= 2'b00;
    end
    if (meas) begin
      n = 0;
      @(negedge ref_clk_i);
      while (reset_out_n_o !== 1'b1 && n < 40000) begin
        n++;
        @(negedge ref_clk_i);
      end
      chk(n[15:0], exp_len(w, s));
      $display("pulse test done");
    end
  endtask : hit
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    num_errors++;
    conclude;
  end
  initial begin
    arst_n_i <= 1'b0;
    m_q = 2'($urandom(32'hbf69));
    repeat (8) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    hit(1'b0, 1'b0, 1'b1);
    m_q <= ~m_q;
    repeat (3) begin
      repeat ($urandom % 20) @(posedge ref_clk_i);
      hit(1'b0, 1'b1, 1'b1);
    end
    hit(1'b1, 1'b0, 1'b0);
    repeat ($urandom % 99) @(posedge ref_clk_i);
    hit(1'b0, 1'b1, 1'b1);
    hit(1'b1, 1'b0, 1'b1);
    chk(clock_mode_o, m_q);
    chk(crystal_drive_enable_o, m_q == 2'h1);
    $display("mode test done");
    @(posedge ref_clk_i) test_port_enable_i <= 1'b1;
    repeat (7) @(negedge ref_clk_i);
    chk({debug_pin_function_o, gpio_debug_ctrl_en_o}, 2'b10);
    $display("test port test done");
    @(posedge ref_clk_i) arst_n_i <= 1'b0;
    @(negedge ref_clk_i);
    chk({reset_out_n_o, core_reset_n_o}, 2'b00);
    $display("reset test done");
    conclude;
  end
endmodule : tb_top

/* src/rsco_cfg.svh */
`ifndef RSCO_CFG_SVH
`define RSCO_CFG_SVH

// reset-out pulse lengths in cpu clocks
`define RSCO_SOFT_PULSE_CYC   16'h0080
`define RSCO_LONG_PULSE_CYC   16'h8000
`define RSCO_CNT_W            16
// clock mode encodings
`define RSCO_MODE_W           2
`define RSCO_MODE_RST_VAL     2'h0
`define RSCO_MODE_CRYSTAL_DRIVE_OUTPUT_OSC    2'h1
// debug pin function select codes
`define RSCO_DBG_FN_GPIO      1'b0
`define RSCO_DBG_FN_TEST      1'b1

`endif

/* src/rsco_pkg.sv */
`include "rsco_cfg.svh"

package rsco_pkg;

  typedef enum logic [1:0] {
    RSCO_IDLE,
    RSCO_PULSE
  } rsco_state_type;

  typedef struct packed {
    rsco_state_type               state;
    logic [`RSCO_CNT_W-1:0]       cnt;
    logic [2:0]                   rst_sync;
    logic                         soft_prev;
    logic [`RSCO_MODE_W-1:0]      mode;
    logic                         clk_half;
    logic [2:0]                   test_sync;
    logic                         test_mode;
  } rsco_regs_type;

endpackage : rsco_pkg

/* src/rsco_reset_clock_out.sv */
// Summary of operation
// - a low primary reset input resets all logic at once through the asynchronous reset path.
// - a rising soft reset request bit with no watchdog timeout in the same cycle drives the reset output low for exactly 128 cpu clocks.
// - a watchdog timeout drives the reset output low for 32K cpu clocks.
// - a low primary reset input also drives the reset output low for 32K cpu clocks.
// - the clock mode select inputs are sampled while reset is active and choose external clock or crystal.
// - the half rate clock output toggles every system clock, giving half the system frequency.
// - while test enable is high the debug pins take the test port function and gpio loses control.
`include "rsco_cfg.svh"

module rsco_reset_clock_out
  import rsco_pkg::*;
(
  // clock and primary reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    arst_n_i,
  // reset causes
  input  wire logic                    soft_reset_request_bit_i,
  input  wire logic                    watchdog_timeout_i,
  // clock mode straps
  input  wire logic [`RSCO_MODE_W-1:0] clock_mode_select_i,
  // test port enable pin
  input  wire logic                    test_port_enable_i,
  // reset out and core reset
  output logic                         reset_out_n_o,
  output logic                         core_reset_n_o,
  // clock selection
  output logic [`RSCO_MODE_W-1:0]      clock_mode_o,
  output logic                         use_crystal_osc_o,
  output logic                         crystal_drive_enable_o,
  // clock output
  output logic                         half_rate_clock_output_o,
  // debug pin function
  output logic                         debug_pin_function_o,
  output logic                         gpio_debug_ctrl_en_o
);

  rsco_regs_type          r_q;
  rsco_regs_type          r_d;

  logic                   rst_sync_done;
  logic                   test_stable;
  logic                   soft_rise;
  logic                   any_cause;
  logic                   strap_window;
  logic                   pulse_last;
  logic [`RSCO_CNT_W-1:0] cause_len;

  // shift one pin sample into a three stage synchroniser
  function automatic logic [2:0] rsco_sync_shift(
    input logic [2:0] sync,
    input logic       din
  );
    rsco_sync_shift = {sync[1:0], din};
  endfunction : rsco_sync_shift

  // a pin change counts once the second and third stage agree
  function automatic logic rsco_sync_agree(
    input logic [2:0] sync
  );
    rsco_sync_agree = (sync[1] == sync[2]);
  endfunction : rsco_sync_agree

  // crystal oscillator only for its own mode code, external clock otherwise
  function automatic logic rsco_is_crystal(
    input logic [`RSCO_MODE_W-1:0] mode
  );
    rsco_is_crystal = (mode == `RSCO_MODE_CRYSTAL_DRIVE_OUTPUT_OSC);
  endfunction : rsco_is_crystal

  // last low cycle of a pulse
  function automatic logic rsco_is_last(
    input logic [`RSCO_CNT_W-1:0] cnt
  );
    rsco_is_last = (cnt == `RSCO_CNT_W'(1));
  endfunction : rsco_is_last

  // pulse length per cause; the long one wins when both arrive together
  function automatic logic [`RSCO_CNT_W-1:0] rsco_pulse_len(
    input logic long_cause
  );
    if (long_cause) begin
      rsco_pulse_len = `RSCO_LONG_PULSE_CYC;
    end else begin
      rsco_pulse_len = `RSCO_SOFT_PULSE_CYC;
    end
  endfunction : rsco_pulse_len

  // reset input release is synchronised; second and third stage must both be high
  assign rst_sync_done = r_q.rst_sync[1] & r_q.rst_sync[2];
  assign test_stable   = rsco_sync_agree(r_q.test_sync);

  // soft request is a level from software, only its rising edge is a cause
  assign soft_rise     = soft_reset_request_bit_i & ~r_q.soft_prev;
  assign any_cause     = watchdog_timeout_i | soft_rise;
  assign cause_len     = rsco_pulse_len(watchdog_timeout_i);

  // straps are watched while the core or the reset out pin is in reset
  assign strap_window  = ~rst_sync_done | (r_q.state == RSCO_PULSE);
  assign pulse_last    = rsco_is_last(r_q.cnt);

  always_comb begin
    r_d = r_q;

    // synchroniser stages
    r_d.rst_sync  = rsco_sync_shift(r_q.rst_sync, 1'b1);
    r_d.test_sync = rsco_sync_shift(r_q.test_sync, test_port_enable_i);
    r_d.soft_prev = soft_reset_request_bit_i;

    r_d.clk_half = ~r_q.clk_half;

    if (strap_window) begin
      r_d.mode = clock_mode_select_i;
    end

    if (test_stable) begin
      r_d.test_mode = r_q.test_sync[2];
    end

    unique case (r_q.state)
      RSCO_IDLE: begin
        r_d.cnt = r_q.cnt;
      end
      RSCO_PULSE: begin
        if (pulse_last) begin
          r_d.state = RSCO_IDLE;
        end
        r_d.cnt = r_q.cnt - `RSCO_CNT_W'(1);
      end
      default: begin
        // an illegal code is treated as a lost reset, safest is a long pulse
        r_d.state = RSCO_PULSE;
        r_d.cnt   = `RSCO_LONG_PULSE_CYC;
      end
    endcase

    if (any_cause) begin
      r_d.state = RSCO_PULSE;
      r_d.cnt   = cause_len;
    end
  end

  // reset state is the long pulse already running
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_q.state     <= RSCO_PULSE;
      r_q.cnt       <= `RSCO_LONG_PULSE_CYC;
      r_q.rst_sync  <= 3'h0;
      r_q.soft_prev <= 1'b0;
      r_q.mode      <= `RSCO_MODE_RST_VAL;
      r_q.clk_half  <= 1'b0;
      r_q.test_sync <= 3'h0;
      r_q.test_mode <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // core stays in reset until the async reset release is synchronised
  assign core_reset_n_o           = rst_sync_done;
  assign reset_out_n_o            = (r_q.state == RSCO_IDLE);
  assign clock_mode_o             = r_q.mode;
  assign use_crystal_osc_o        = rsco_is_crystal(r_q.mode);
  // the crystal driver only runs when the internal oscillator is used
  assign crystal_drive_enable_o   = rsco_is_crystal(r_q.mode);
  assign half_rate_clock_output_o = r_q.clk_half;
  assign debug_pin_function_o     = r_q.test_mode ? `RSCO_DBG_FN_TEST : `RSCO_DBG_FN_GPIO;
  assign gpio_debug_ctrl_en_o     = ~r_q.test_mode;

endmodule : rsco_reset_clock_out
